// file: core/lpc_core.sv
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "lpc_params.svh"

module lpc_core
#(
	parameter int REG_START_CYC = `LPC_REG_START_CYC
)
(
	input wire logic core_clk, // 20 MHz clock
	input wire logic reset, // Async reset, active high
	input wire logic [`LPC_ADDR_W-1:0] reg_addr, // Register byte address
	input wire logic [`LPC_DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [`LPC_DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
	input wire logic deep_sleep_select, // Processor deep-sleep select bit
	input wire logic wait_for_interrupt_instr, // Pulse when core executes the instruction
	input wire logic irq_pending, // Any enabled interrupt pending
	input wire logic [15:0] wake_pins, // Asynchronous wake pins
	input wire logic supply_monitor_alarm, // Asynchronous supply monitor alarm
	input wire logic calendar_alarm, // Asynchronous calendar alarm
	input wire logic timer_alarm, // Asynchronous real-time timer alarm
	input wire logic usb_wake, // Asynchronous USB wake-up
	output lpc_pkg::lpc_state_t mode, // Current power state
	output logic core_clk_en, // Core clock gate
	output logic periph_clk_en, // Peripheral clock gate
	output logic mem_clk_en, // Memory clock gate
	output logic regulator_on, // Core regulators enable
	output logic core_supply_on, // Core supply switch
	output logic sram_supply_on, // SRAM supply switch
	output logic periph_supply_on, // Peripheral supply switch
	output logic transceiver_on, // Power-line transceiver supply
	output logic backup_region_on, // Backup region supply
	output logic fast_rc_on, // Fast RC oscillator enable
	output logic main_clk_rc_sel, // Master clock taken from fast RC 4 MHz
	output logic pll_enable, // PLL enable
	output logic core_reset, // Core held in reset
	output logic irq // Level interrupt
);
	import lpc_pkg::*;

	lpc_state_t state_ff, nxt_state;
	logic [`LPC_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [11:0] cfg_ff;
	logic [`LPC_SRC_W-1:0] wake_en_ff, fast_en_ff;
	logic [`LPC_DOM_W-1:0] dom_ff;
	logic [`LPC_IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_set;
	logic [`LPC_DATA_W-1:0] rdata_ff;
	logic wait_req_ff, regoff_ff, master_clock_ready_flag_ff, rc_en_ff, rc_sel_ff, pll_ff, core_rst_ff;
	logic from_backup_ff;
	logic [19:0] src_s1_ff, src_s2_ff;
	logic [15:0] pin_stable_ff, pin_edge;
	logic [15:0] slow_cnt_ff;
	logic slow_tick;
	logic wr_ctrl, lp_cfg, flash_low_power_field_ok, backup_wake, fast_wake;

	function automatic logic hit(input logic [`LPC_ADDR_W-1:0] ofs);
		hit = (reg_addr == ofs);
	endfunction

	assign wr_ctrl = reg_wr && hit(`LPC_OFS_CTRL);
	assign flash_low_power_field_ok = ~cfg_ff[`LPC_CFG_FLASH_LOW_POWER_FIELD_HI];
	assign lp_cfg = cfg_ff[`LPC_CFG_LPSEL] || (state_ff != LPC_ACTIVE);

	// Two-stage synchronisers for pins and alarms
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			// Pins idle high; a low reset value would fake a transition
			src_s1_ff <= `LPC_SRC_IDLE;
			src_s2_ff <= `LPC_SRC_IDLE;
		end
		else
		begin
			src_s1_ff <= {usb_wake, timer_alarm, calendar_alarm, supply_monitor_alarm, wake_pins};
			src_s2_ff <= src_s1_ff;
		end
	end

	// Slow-clock enable for debouncing, as the backup region ticks at 32 kHz
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			slow_cnt_ff <= 16'h0000;
		else if (slow_tick)
			slow_cnt_ff <= 16'h0000;
		else
			slow_cnt_ff <= slow_cnt_ff + 16'h0001;
	end
	assign slow_tick = (slow_cnt_ff == 16'((`LPC_SLOW_DIV) - 1));

	// Per-pin debounce: level must hold for the configured slow ticks
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_deb
			logic [3:0] deb_ff;
			always_ff @(posedge core_clk or posedge reset)
			begin
				if (reset)
				begin
					deb_ff <= 4'h0;
					pin_stable_ff[gi] <= 1'b1;
				end
				else if (src_s2_ff[gi] == pin_stable_ff[gi])
					deb_ff <= 4'h0;
				else if (deb_ff >= cfg_ff[`LPC_CFG_DEB_HI:`LPC_CFG_DEB_LO])
				begin
					deb_ff <= 4'h0;
					pin_stable_ff[gi] <= src_s2_ff[gi];
				end
				else if (slow_tick)
					deb_ff <= deb_ff + 4'h1;
			end
			assign pin_edge[gi] = (src_s2_ff[gi] != pin_stable_ff[gi]) &&
				(deb_ff >= cfg_ff[`LPC_CFG_DEB_HI:`LPC_CFG_DEB_LO]);
		end
	endgenerate

	// Backup wake: debounced transitions plus alarms, each gated by its enable
	assign backup_wake = |(pin_edge & wake_en_ff[15:0]) ||
		|(src_s2_ff[`LPC_SRC_RTT:`LPC_SRC_SM] & wake_en_ff[`LPC_SRC_RTT:`LPC_SRC_SM]);
	// Fast start-up: low level on fast pins, alarms, USB wake
	assign fast_wake = |(~src_s2_ff[15:0] & fast_en_ff[15:0]) ||
		|(src_s2_ff[`LPC_SRC_USB:`LPC_SRC_SM] & fast_en_ff[`LPC_SRC_USB:`LPC_SRC_SM]);

	// Configuration registers
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			cfg_ff <= `LPC_CFG_RST;
			wake_en_ff <= `LPC_WAKE_RST;
			fast_en_ff <= `LPC_WAKE_RST;
			dom_ff <= `LPC_DOM_RST;
			irq_mask_ff <= 4'h0;
		end
		else if (reg_wr)
		begin
			if (hit(`LPC_OFS_CFG))
				cfg_ff <= reg_wdata[11:0];
			if (hit(`LPC_OFS_WAKE_EN))
				wake_en_ff <= reg_wdata[`LPC_SRC_W-1:0];
			if (hit(`LPC_OFS_FAST_EN))
				fast_en_ff <= reg_wdata[`LPC_SRC_W-1:0];
			if (hit(`LPC_OFS_DOMAIN))
				dom_ff <= reg_wdata[`LPC_DOM_W-1:0];
			if (hit(`LPC_OFS_IRQ_MASK))
				irq_mask_ff <= reg_wdata[`LPC_IRQ_W-1:0];
		end
	end

	// Entry requests latched from control writes
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			wait_req_ff <= 1'b0;
			regoff_ff <= 1'b0;
		end
		else
		begin
			wait_req_ff <= wr_ctrl && reg_wdata[`LPC_CTRL_WAITREQ] &&
				cfg_ff[`LPC_CFG_LPSEL] && flash_low_power_field_ok;
			regoff_ff <= wr_ctrl && reg_wdata[`LPC_CTRL_REGOFF] && deep_sleep_select;
		end
	end

	// Mode sequencer
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			LPC_ACTIVE:
			begin
				nxt_cnt = '0;
				if (regoff_ff)
					nxt_state = LPC_BACKUP;
				else if (wait_req_ff)
					nxt_state = LPC_WAIT_SYNC;
				else if (wait_for_interrupt_instr && !cfg_ff[`LPC_CFG_LPSEL] && !irq_pending)
					nxt_state = LPC_SLEEP;
			end
			LPC_SLEEP:
			begin
				if (irq_pending)
					nxt_state = LPC_ACTIVE;
			end
			LPC_WAIT_SYNC:
			begin
				// Resync delay to the main clock domain before clocks stop
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == `LPC_CNT_W'(`LPC_RESYNC_CYC - 1))
				begin
					nxt_state = LPC_WAIT;
					nxt_cnt = '0;
				end
			end
			LPC_WAIT:
			begin
				nxt_cnt = '0;
				if (fast_wake)
					nxt_state = LPC_WAKE;
			end
			LPC_BACKUP:
			begin
				nxt_cnt = '0;
				if (backup_wake)
					nxt_state = LPC_WAKE;
			end
			LPC_WAKE:
			begin
				// Regulator start-up from backup, RC start-up from wait
				nxt_cnt = cnt_ff + 1'b1;
				if (from_backup_ff ? (cnt_ff == `LPC_CNT_W'(REG_START_CYC - 1)) :
					(cnt_ff == `LPC_CNT_W'(`LPC_RC_START_CYC - 1)))
					nxt_state = LPC_ACTIVE;
			end
			default:
			begin
				nxt_state = LPC_ACTIVE;
				nxt_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_ff <= LPC_ACTIVE;
			cnt_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			from_backup_ff <= 1'b0;
		else if (state_ff == LPC_BACKUP)
			from_backup_ff <= 1'b1;
		else if (state_ff == LPC_WAIT)
			from_backup_ff <= 1'b0;
	end

	// Clock source status: master clock ready is low from wait or backup entry until the wake restart ends
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			master_clock_ready_flag_ff <= 1'b1;
			rc_en_ff <= 1'b1;
			rc_sel_ff <= 1'b1;
			pll_ff <= 1'b0;
		end
		else if (nxt_state == LPC_WAKE && state_ff != LPC_WAKE)
		begin
			rc_en_ff <= 1'b1;
			rc_sel_ff <= 1'b1;
			pll_ff <= 1'b0;
		end
		else if (nxt_state == LPC_ACTIVE && state_ff == LPC_WAKE)
			master_clock_ready_flag_ff <= 1'b1;
		else if (state_ff == LPC_WAIT_SYNC || state_ff == LPC_BACKUP)
		begin
			master_clock_ready_flag_ff <= 1'b0;
			if (nxt_state == LPC_WAIT || state_ff == LPC_BACKUP)
				rc_en_ff <= 1'b0;
		end
		else if (reg_wr && hit(`LPC_OFS_CFG))
		begin
			pll_ff <= reg_wdata[`LPC_CFG_PLL];
			if (reg_wdata[`LPC_CFG_PLL])
				rc_sel_ff <= 1'b0;
		end
	end

	// Core held in reset across backup and its recovery
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			core_rst_ff <= 1'b0;
		else if (state_ff == LPC_BACKUP)
			core_rst_ff <= 1'b1;
		else if (state_ff == LPC_WAKE && nxt_state == LPC_ACTIVE)
			core_rst_ff <= 1'b0;
	end

	// Sticky interrupt events, set wins over write-one clear
	always_comb
	begin
		irq_set = '0;
		irq_set[`LPC_IRQ_BACKUP_WAKE] = (state_ff == LPC_BACKUP) && (nxt_state == LPC_WAKE);
		irq_set[`LPC_IRQ_WAIT_WAKE] = (state_ff == LPC_WAIT) && (nxt_state == LPC_WAKE);
		irq_set[`LPC_IRQ_SLEEP_WAKE] = (state_ff == LPC_SLEEP) && (nxt_state == LPC_ACTIVE);
		irq_set[`LPC_IRQ_WAIT_ENTER] = (state_ff == LPC_WAIT_SYNC) && (nxt_state == LPC_WAIT);
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			irq_stat_ff <= '0;
		else if (reg_wr && hit(`LPC_OFS_IRQ_STAT))
			irq_stat_ff <= (irq_stat_ff & ~reg_wdata[`LPC_IRQ_W-1:0]) | irq_set;
		else
			irq_stat_ff <= irq_stat_ff | irq_set;
	end

	// Read data, one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			rdata_ff <= '0;
		else if (reg_rd)
		begin
			rdata_ff <= '0;
			case (reg_addr)
				`LPC_OFS_CFG: rdata_ff[11:0] <= cfg_ff;
				`LPC_OFS_WAKE_EN: rdata_ff[`LPC_SRC_W-1:0] <= wake_en_ff;
				`LPC_OFS_FAST_EN: rdata_ff[`LPC_SRC_W-1:0] <= fast_en_ff;
				`LPC_OFS_DOMAIN: rdata_ff[`LPC_DOM_W-1:0] <= dom_ff;
				`LPC_OFS_STATUS:
				begin
					rdata_ff[5:0] <= state_ff;
					rdata_ff[`LPC_ST_MASTER_CLOCK_READY_FLAG] <= master_clock_ready_flag_ff;
					rdata_ff[`LPC_ST_RCEN] <= rc_en_ff;
					rdata_ff[`LPC_ST_RCSEL] <= rc_sel_ff;
				end
				`LPC_OFS_IRQ_STAT: rdata_ff[`LPC_IRQ_W-1:0] <= irq_stat_ff;
				`LPC_OFS_IRQ_MASK: rdata_ff[`LPC_IRQ_W-1:0] <= irq_mask_ff;
				default: rdata_ff <= '0;
			endcase
		end
		else
			rdata_ff <= '0;
	end

	assign reg_rdata = rdata_ff;
	assign irq = |(irq_stat_ff & irq_mask_ff);
	assign mode = state_ff;

	// Power and clock gating per state
	assign core_clk_en = (state_ff == LPC_ACTIVE) || (state_ff == LPC_WAIT_SYNC);
	assign periph_clk_en = dom_ff[`LPC_DOM_PERIPH] &&
		(state_ff == LPC_ACTIVE || state_ff == LPC_SLEEP || state_ff == LPC_WAIT_SYNC);
	assign mem_clk_en = dom_ff[`LPC_DOM_MEM] &&
		(state_ff == LPC_ACTIVE || state_ff == LPC_SLEEP || state_ff == LPC_WAIT_SYNC);
	assign regulator_on = (state_ff != LPC_BACKUP);
	assign core_supply_on = (state_ff != LPC_BACKUP);
	assign sram_supply_on = dom_ff[`LPC_DOM_MEM] && (state_ff != LPC_BACKUP);
	assign periph_supply_on = dom_ff[`LPC_DOM_PERIPH] && (state_ff != LPC_BACKUP);
	assign transceiver_on = dom_ff[`LPC_DOM_XCVR] && !lp_cfg;
	assign backup_region_on = 1'b1;
	assign fast_rc_on = rc_en_ff;
	assign main_clk_rc_sel = rc_sel_ff;
	assign pll_enable = pll_ff;
	assign core_reset = core_rst_ff;
endmodule

// file: inc/lpc_params.svh
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH

`define LPC_ADDR_W 8
`define LPC_DATA_W 32

// Register byte offsets
`define LPC_OFS_CTRL 8'h00
`define LPC_OFS_CFG 8'h04
`define LPC_OFS_WAKE_EN 8'h08
`define LPC_OFS_FAST_EN 8'h0c
`define LPC_OFS_DOMAIN 8'h10
`define LPC_OFS_STATUS 8'h14
`define LPC_OFS_IRQ_STAT 8'h18
`define LPC_OFS_IRQ_MASK 8'h1c

// Control register fields
`define LPC_CTRL_REGOFF 0
`define LPC_CTRL_WAITREQ 1

// Configuration register fields
`define LPC_CFG_LPSEL 0
`define LPC_CFG_FLASH_LOW_POWER_FIELD_LO 1
`define LPC_CFG_FLASH_LOW_POWER_FIELD_HI 2
`define LPC_CFG_FWS_LO 3
`define LPC_CFG_FWS_HI 6
`define LPC_CFG_PLL 7
`define LPC_CFG_DEB_LO 8
`define LPC_CFG_DEB_HI 11
`define LPC_CFG_RST 12'h002

// Wake source enable layout
`define LPC_SRC_W 20
`define LPC_SRC_SM 16
`define LPC_SRC_RTC 17
`define LPC_SRC_RTT 18
`define LPC_SRC_USB 19
`define LPC_WAKE_RST 20'h00000
`define LPC_SRC_IDLE 20'h0ffff

// Domain switch register
`define LPC_DOM_W 3
`define LPC_DOM_PERIPH 0
`define LPC_DOM_MEM 1
`define LPC_DOM_XCVR 2
`define LPC_DOM_RST 3'h7

// Status register fields
`define LPC_ST_MASTER_CLOCK_READY_FLAG 8
`define LPC_ST_RCEN 9
`define LPC_ST_RCSEL 10

// Interrupt events
`define LPC_IRQ_W 4
`define LPC_IRQ_BACKUP_WAKE 0
`define LPC_IRQ_WAIT_WAKE 1
`define LPC_IRQ_SLEEP_WAKE 2
`define LPC_IRQ_WAIT_ENTER 3

// Timing
`define LPC_CLK_HZ 20000000
`define LPC_SLOW_HZ 32768
`define LPC_SLOW_DIV (`LPC_CLK_HZ / `LPC_SLOW_HZ)
`define LPC_RESYNC_CYC 4
`define LPC_RC_START_NS 5000
`define LPC_RC_START_CYC ((`LPC_RC_START_NS * (`LPC_CLK_HZ / 1000000) + 999) / 1000)
`define LPC_WAIT_WAKE_MAX_NS 10000
`define LPC_REG_START_US 300
`define LPC_REG_START_CYC (`LPC_REG_START_US * (`LPC_CLK_HZ / 1000000))
`define LPC_BACKUP_WAKE_MAX_US 500
`define LPC_CNT_W 14

`endif

// file: inc/lpc_pkg.sv
package lpc_pkg;
	typedef enum logic [5:0]
	{
		LPC_ACTIVE = 6'h01,
		LPC_SLEEP = 6'h02,
		LPC_WAIT_SYNC = 6'h04,
		LPC_WAIT = 6'h08,
		LPC_BACKUP = 6'h10,
		LPC_WAKE = 6'h20
	} lpc_state_t;
endpackage

// file: testbench/lpc_core_chk.sv
`timescale 1ns/1ns
`include "lpc_params.svh"
module lpc_core_chk
#(
	parameter int REG_START_CYC = `LPC_REG_START_CYC
)
(
	input wire logic core_clk, // Clock
	input wire logic reset, // Async reset
	input wire logic reg_wr, // Write strobe
	input wire logic deep_sleep_select, // Deep-sleep bit
	input wire logic irq_pending, // Pending interrupt
	input wire lpc_pkg::lpc_state_t mode, // Power state
	input wire logic core_clk_en, // Core clock gate
	input wire logic periph_clk_en, // Peripheral clock gate
	input wire logic mem_clk_en, // Memory clock gate
	input wire logic regulator_on, // Regulators
	input wire logic core_supply_on, // Core supply
	input wire logic transceiver_on, // Transceiver supply
	input wire logic backup_region_on, // Backup region
	input wire logic fast_rc_on, // Fast RC enable
	input wire logic main_clk_rc_sel, // RC as master clock
	input wire logic pll_enable // PLL enable
);
	import lpc_pkg::*;
	logic [13:0] wake_cnt_ff;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// Cycles spent restarting after a wake event
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			wake_cnt_ff <= 14'h0;
		else if (mode == LPC_WAKE)
			wake_cnt_ff <= wake_cnt_ff + 14'h1;
		else
			wake_cnt_ff <= 14'h0;
	end

	property p_xcvr_off;
		mode != LPC_ACTIVE |-> !transceiver_on;
	endproperty
	a_xcvr_off: assert property (p_xcvr_off) else $error("transceiver on in low power");
	property p_backup_pwr;
		mode == LPC_BACKUP |-> !regulator_on && !core_supply_on && backup_region_on;
	endproperty
	a_backup_pwr: assert property (p_backup_pwr) else $error("backup supplies wrong");
	property p_wait_clk;
		mode == LPC_WAIT |-> !core_clk_en && !periph_clk_en && !mem_clk_en && core_supply_on;
	endproperty
	a_wait_clk: assert property (p_wait_clk) else $error("wait clocks or supply wrong");
	property p_sleep_clk;
		mode == LPC_SLEEP |-> !core_clk_en && core_supply_on && regulator_on;
	endproperty
	a_sleep_clk: assert property (p_sleep_clk) else $error("sleep gating wrong");
	property p_sync_len;
		$rose(mode == LPC_WAIT_SYNC) |-> (mode == LPC_WAIT_SYNC) [*4] ##1 mode == LPC_WAIT;
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("wait entry delay wrong");
	property p_sleep_wake;
		mode == LPC_SLEEP && irq_pending |=> mode == LPC_ACTIVE;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep did not wake");
	property p_wake_rc;
		$rose(mode == LPC_WAKE) |-> ##1 fast_rc_on && main_clk_rc_sel && !pll_enable;
	endproperty
	a_wake_rc: assert property (p_wake_rc) else $error("wake clock not fast RC");
	property p_backup_exit;
		$past(mode) == LPC_BACKUP && mode != LPC_BACKUP |-> regulator_on && core_supply_on;
	endproperty
	a_backup_exit: assert property (p_backup_exit) else $error("supply not restored");
	property p_wait_wake_time;
		$rose(mode == LPC_WAKE) && $past(mode) == LPC_WAIT |-> ##[1:199] mode == LPC_ACTIVE;
	endproperty
	a_wait_wake_time: assert property (p_wait_wake_time) else $error("wait wake slow");
	property p_wake_len;
		wake_cnt_ff < 10000 && wake_cnt_ff <= REG_START_CYC + 200;
	endproperty
	a_wake_len: assert property (p_wake_len) else $error("wake restart too long");
	property p_backup_cause;
		$rose(mode == LPC_BACKUP) |-> $past(deep_sleep_select, 2) && $past(reg_wr, 2);
	endproperty
	a_backup_cause: assert property (p_backup_cause) else $error("backup without cause");

	c_wait: cover property (mode == LPC_WAIT);
	c_backup_exit: cover property ($fell(mode == LPC_BACKUP));
	c_sleep_wake: cover property (mode == LPC_SLEEP && irq_pending);
endmodule

bind lpc_core lpc_core_chk #(.REG_START_CYC(REG_START_CYC)) lpc_core_chk_inst (.core_clk,
	.reset, .reg_wr, .deep_sleep_select, .irq_pending, .mode, .core_clk_en, .periph_clk_en,
	.mem_clk_en, .regulator_on, .core_supply_on, .transceiver_on, .backup_region_on,
	.fast_rc_on, .main_clk_rc_sel, .pll_enable);

// file: testbench/lpc_far_model.sv
`timescale 1ns/1ns
module lpc_far_model
(
	input wire logic core_clk, // Clock
	output logic deep_sleep_select, // Core deep-sleep bit
	output logic wait_for_interrupt_instr, // Instruction pulse
	output logic irq_pending, // Enabled interrupt pending
	output logic [15:0] wake_pins, // Pins, idle high
	output logic supply_monitor_alarm, // Monitor alarm
	output logic calendar_alarm, // Calendar alarm
	output logic timer_alarm, // Timer alarm
	output logic usb_wake // USB wake-up
);
	initial
	begin
		deep_sleep_select = 1'b0;
		wait_for_interrupt_instr = 1'b0;
		irq_pending = 1'b0;
		wake_pins = 16'hffff;
		{usb_wake, timer_alarm, calendar_alarm, supply_monitor_alarm} = 4'h0;
	end

	task set_deep(input logic v);
		@(posedge core_clk);
		deep_sleep_select <= v;
	endtask

	task set_irq(input logic v);
		@(posedge core_clk);
		irq_pending <= v;
	endtask

	task do_wfi();
		@(posedge core_clk);
		wait_for_interrupt_instr <= 1'b1;
		@(posedge core_clk);
		wait_for_interrupt_instr <= 1'b0;
	endtask

	// Bits 15:0 pull pins low, 16 monitor, 17 calendar, 18 timer, 19 usb
	task fire(input logic [19:0] src, input int n);
		@(posedge core_clk);
		wake_pins <= ~src[15:0];
		supply_monitor_alarm <= src[16];
		calendar_alarm <= src[17];
		timer_alarm <= src[18];
		usb_wake <= src[19];
		repeat (n) @(posedge core_clk);
		wake_pins <= 16'hffff;
		supply_monitor_alarm <= 1'b0;
		calendar_alarm <= 1'b0;
		timer_alarm <= 1'b0;
		usb_wake <= 1'b0;
	endtask
endmodule

// file: testbench/lpc_core_tb.sv
`timescale 1ns/1ns
`include "lpc_params.svh"
`define CHK(g, e) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module lpc_core_tb;
	import lpc_pkg::*;
	logic core_clk, reset, reg_wr, reg_rd;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic deep_sleep_select, wait_for_interrupt_instr, irq_pending;
	logic supply_monitor_alarm, calendar_alarm, timer_alarm, usb_wake;
	logic [15:0] wake_pins;
	lpc_state_t mode;
	logic core_clk_en, periph_clk_en, mem_clk_en, regulator_on, core_supply_on;
	logic sram_supply_on, periph_supply_on, transceiver_on, backup_region_on;
	logic fast_rc_on, main_clk_rc_sel, pll_enable, core_reset, irq;
	int error_cnt, checks_done, cyc, i, n;
	logic [19:0] srcw [4] = '{20'h00020, 20'h20000, 20'h40000, 20'h80000};
	logic [19:0] srcb [4] = '{20'h08000, 20'h10000, 20'h20000, 20'h40000};

	lpc_core #(.REG_START_CYC(20)) lpc_core_inst (.core_clk, .reset, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .deep_sleep_select, .wait_for_interrupt_instr,
		.irq_pending, .wake_pins, .supply_monitor_alarm, .calendar_alarm, .timer_alarm,
		.usb_wake, .mode, .core_clk_en, .periph_clk_en, .mem_clk_en, .regulator_on,
		.core_supply_on, .sram_supply_on, .periph_supply_on, .transceiver_on,
		.backup_region_on, .fast_rc_on, .main_clk_rc_sel, .pll_enable, .core_reset, .irq);
	lpc_far_model lpc_far_model_inst (.core_clk, .deep_sleep_select, .wait_for_interrupt_instr,
		.irq_pending, .wake_pins, .supply_monitor_alarm, .calendar_alarm, .timer_alarm,
		.usb_wake);

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task end_of_test();
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Idle edge after each strobe keeps one assignment per time step
	task wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task chk_rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		// Read data stand only in the cycle after the strobe
		#1 `CHK(reg_rdata, e)
		@(posedge core_clk);
	endtask

	task wait_mode(input lpc_state_t m, input int lim);
		n = 0;
		while (mode !== m && n < lim)
		begin
			@(posedge core_clk);
			n++;
		end
	endtask

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end

	initial
	begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		chk_rd(8'h04, 32'h002);
		chk_rd(8'h10, 32'h007);
		chk_rd(8'h14, 32'h701);
		chk_rd(8'h00, 32'h0);
		chk_rd(8'h20, 32'h0);
		`CHK(transceiver_on, 1'b1)
		wr(8'h10, 32'h0);
		`CHK({periph_supply_on, sram_supply_on, transceiver_on}, 3'h0)
		wr(8'h10, 32'h7);
		$display("Test reset and domains done");

		wr(8'h00, 32'h1);
		chk_rd(8'h14, 32'h701);
		lpc_far_model_inst.set_irq(1'b1);
		lpc_far_model_inst.do_wfi();
		#1 `CHK(mode, LPC_ACTIVE)
		lpc_far_model_inst.set_irq(1'b0);
		lpc_far_model_inst.do_wfi();
		#1 `CHK(mode, LPC_SLEEP)
		`CHK({core_clk_en, periph_clk_en, core_supply_on}, 3'h3)
		`CHK(transceiver_on, 1'b0)
		lpc_far_model_inst.set_irq(1'b1);
		@(posedge core_clk);
		#1 `CHK(mode, LPC_ACTIVE)
		lpc_far_model_inst.set_irq(1'b0);
		`CHK(irq, 1'b0)
		wr(8'h1c, 32'h4);
		`CHK(irq, 1'b1)
		wr(8'h18, 32'h4);
		`CHK(irq, 1'b0)
		chk_rd(8'h18, 32'h0);
		$display("Test sleep done");

		wr(8'h04, 32'h5);
		`CHK(transceiver_on, 1'b0)
		wr(8'h00, 32'h2);
		chk_rd(8'h14, 32'h701);
		wr(8'h04, 32'h1);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h0c, {12'h0, srcw[i]});
			wr(8'h00, 32'h2);
			#1 `CHK(mode, LPC_WAIT_SYNC)
			repeat (4) @(posedge core_clk);
			#1 `CHK(mode, LPC_WAIT)
			`CHK({core_clk_en, periph_clk_en, mem_clk_en, core_supply_on}, 4'h1)
			chk_rd(8'h14, 32'h408);
			lpc_far_model_inst.fire(srcw[i] ^ 20'hfffff, 8);
			`CHK(mode, LPC_WAIT)
			fork
				lpc_far_model_inst.fire(srcw[i], 8);
				wait_mode(LPC_ACTIVE, 200);
			join
			`CHK(n < 200, 1'b1)
			`CHK({fast_rc_on, main_clk_rc_sel, pll_enable}, 3'h6)
			chk_rd(8'h14, 32'h701);
			chk_rd(8'h18, 32'ha);
			wr(8'h18, 32'hf);
		end
		$display("Test wait done");

		wr(8'h04, 32'h2);
		lpc_far_model_inst.set_deep(1'b1);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h08, {12'h0, srcb[i]});
			wr(8'h00, 32'h1);
			#1 `CHK(mode, LPC_BACKUP)
			`CHK({regulator_on, core_supply_on, transceiver_on, backup_region_on}, 4'h1)
			lpc_far_model_inst.fire(srcb[i] ^ 20'hfffff, 8);
			`CHK(mode, LPC_BACKUP)
			fork
				lpc_far_model_inst.fire(srcb[i], 1500);
				wait_mode(LPC_ACTIVE, 10000);
			join
			`CHK(n < 10000, 1'b1)
			`CHK({core_supply_on, sram_supply_on, core_reset}, 3'h6)
			chk_rd(8'h18, 32'h1);
			wr(8'h18, 32'hf);
		end
		$display("Test backup done");
		end_of_test();
	end
endmodule
